// >>> rtl/sdcp_parser.sv
// direct-execution command parser: frame decode, init, homing, homing speeds
`timescale 1ns/100ps
`include "sdcp_regs.svh"
module sdcp_parser (
    input  wire logic        clk_sys_in,
    input  wire logic        srst_in,
    input  wire logic        clk_en_in,
    input  wire logic [7:0]  rx_data_in,
    input  wire logic        rx_valid_in,
    output logic             tx_valid_out,
    output logic [7:0]       tx_data_out,
    input  wire logic        tx_ready_in,
    input  wire logic        interp_3d_in,
    output logic             interp_3d_clear_out,
    input  wire logic [3:0]  ref_switch_in,
    input  wire logic        stop_button_in,
    output logic             home_active_out,
    output logic [1:0]       home_axis_out,
    output logic [15:0]      home_speed_out,
    output logic [3:0]       axis_config_out,
    output logic             initialised_out
);
    // =====================================================
    // helpers
    function automatic logic is_digit(input logic [7:0] c);
        return (c >= `SDCP_CH_ZERO) && (c <= `SDCP_CH_NINE);
    endfunction

    function automatic logic [15:0] acc_digit(input logic [15:0] v, input logic [7:0] c);
        logic [19:0] t;
        t = 20'(v) * 20'h0000A + 20'(c - `SDCP_CH_ZERO);
        return (t[19:16] != 4'h0) ? '1 : t[15:0];
    endfunction

    // highest pending axis in Z, Y, X, A order
    function automatic logic [1:0] next_axis(input logic [3:0] m);
        if (m[`SDCP_BIT_Z]) return `SDCP_AXIS_Z;
        if (m[`SDCP_BIT_Y]) return `SDCP_AXIS_Y;
        if (m[`SDCP_BIT_X]) return `SDCP_AXIS_X;
        return `SDCP_AXIS_A;
    endfunction

    // =====================================================
    // state
    sdcp_pkg::sdcp_state_type state_reg, state_next;
    sdcp_pkg::sdcp_cmd_type   cmd_reg, cmd_next;
    logic [3:0]  unit_number_reg, unit_number_next;
    logic [15:0] value_reg, value_next;
    logic [2:0]  digits_reg, digits_next;
    logic [2:0]  field_reg, field_next;
    logic        bad_reg, bad_next;
    logic [3:0]  config_reg, config_next;
    logic        init_reg, init_next;
    logic [3:0]  pending_reg, pending_next;
    logic [1:0]  axis_reg, axis_next;
    logic [7:0]  reply_reg, reply_next;
    logic        clr3d_reg, clr3d_next;
    logic        rd_wait_reg, rd_wait_next;
    logic [15:0] stage_reg [4], stage_next [4];

    sdcp_speed_if spd ();

    sdcp_speed_mem u_mem (
        .clk_sys_in (clk_sys_in),
        .srst_in    (srst_in),
        .clk_en_in  (clk_en_in),
        .port       (spd.mem)
    );

    logic axis_done;
    assign axis_done = ref_switch_in[axis_reg] || stop_button_in;

    // =====================================================
    // next state
    always_comb begin
        state_next       = state_reg;
        cmd_next         = cmd_reg;
        unit_number_next = unit_number_reg;
        value_next       = value_reg;
        digits_next      = digits_reg;
        field_next       = field_reg;
        bad_next         = bad_reg;
        config_next      = config_reg;
        init_next        = init_reg;
        pending_next     = pending_reg;
        axis_next        = axis_reg;
        reply_next       = reply_reg;
        clr3d_next       = 1'b0;
        rd_wait_next     = 1'b0;
        stage_next       = stage_reg;
        spd.wr_en        = 1'b0;
        spd.wr_addr      = field_reg[1:0];
        spd.wr_data      = value_reg;
        spd.rd_addr      = axis_reg;
        unique case (state_reg)
            sdcp_pkg::SDCP_IDLE: begin
                if (rx_valid_in && rx_data_in == `SDCP_CH_OPEN) begin
                    state_next  = sdcp_pkg::SDCP_UNIT;
                    value_next  = 16'h0000;
                    digits_next = 3'h0;
                    field_next  = 3'h0;
                    bad_next    = 1'b0;
                end
            end
            sdcp_pkg::SDCP_UNIT: begin
                if (rx_valid_in) begin
                    state_next = sdcp_pkg::SDCP_BODY;
                    if (is_digit(rx_data_in)) begin
                        unit_number_next = 4'(rx_data_in - `SDCP_CH_ZERO);
                    end else begin
                        bad_next = 1'b1;
                    end
                    if (unit_number_next != `SDCP_UNIT_DEFAULT) begin
                        bad_next = 1'b1;
                    end
                    cmd_next = sdcp_pkg::SDCP_CMD_INIT;
                end
            end
            sdcp_pkg::SDCP_BODY: begin
                if (rx_valid_in) begin
                    if (rx_data_in == `SDCP_CH_CR) begin
                        state_next = sdcp_pkg::SDCP_EXEC;
                    end else if (is_digit(rx_data_in)) begin
                        value_next  = acc_digit(value_reg, rx_data_in);
                        digits_next = digits_reg + 3'h1;
                        if (digits_reg == `SDCP_DIGIT_MAX) begin
                            bad_next = 1'b1;
                        end
                    end else if (digits_reg == 3'h0 && field_reg == 3'h0 &&
                                 cmd_reg == sdcp_pkg::SDCP_CMD_INIT) begin
                        if (rx_data_in == `SDCP_CH_HOME_UC ||
                            rx_data_in == `SDCP_CH_HOME_LC) begin
                            cmd_next = sdcp_pkg::SDCP_CMD_HOME;
                        end else if (rx_data_in == `SDCP_CH_SPEED) begin
                            cmd_next = sdcp_pkg::SDCP_CMD_SPEED;
                        end else begin
                            cmd_next = sdcp_pkg::SDCP_CMD_BAD;
                        end
                    end else if (rx_data_in == `SDCP_CH_COMMA &&
                                 cmd_reg == sdcp_pkg::SDCP_CMD_SPEED) begin
                        // earlier fields wait in stage until the whole frame is good
                        if (value_reg < `SDCP_SPEED_MIN || value_reg > `SDCP_SPEED_MAX ||
                            digits_reg == 3'h0 || field_reg == 3'h3) begin
                            bad_next = 1'b1;
                        end
                        stage_next[field_reg[1:0]] = value_reg;
                        field_next  = field_reg + 3'h1;
                        value_next  = 16'h0000;
                        digits_next = 3'h0;
                    end else begin
                        bad_next = 1'b1;
                    end
                end
            end
            sdcp_pkg::SDCP_EXEC: begin
                state_next = sdcp_pkg::SDCP_REPLY;
                reply_next = `SDCP_CH_ACK;
                if (bad_reg || digits_reg == 3'h0 || cmd_reg == sdcp_pkg::SDCP_CMD_BAD) begin
                    reply_next = (cmd_reg == sdcp_pkg::SDCP_CMD_BAD) ?
                                 `SDCP_CH_ERR_CMD : `SDCP_CH_ERR_SYNTAX;
                end else begin
                    unique case (cmd_reg)
                        sdcp_pkg::SDCP_CMD_INIT: begin
                            if (value_reg == 16'(`SDCP_AXES_X) ||
                                value_reg == 16'(`SDCP_AXES_XY) ||
                                value_reg == 16'(`SDCP_AXES_XYZ) ||
                                value_reg == 16'(`SDCP_AXES_A)) begin
                                config_next = value_reg[3:0];
                                init_next   = 1'b1;
                            end else begin
                                reply_next = `SDCP_CH_ERR_AXES;
                            end
                        end
                        sdcp_pkg::SDCP_CMD_HOME: begin
                            if (!init_reg) begin
                                reply_next = `SDCP_CH_ERR_NOINIT;
                            end else if (value_reg == 16'h0000 || value_reg[15:4] != 12'h000 ||
                                         (value_reg[3:0] & ~config_reg) != 4'h0) begin
                                reply_next = `SDCP_CH_ERR_AXES;
                            end else begin
                                pending_next = value_reg[3:0];
                                axis_next    = next_axis(value_reg[3:0]);
                                rd_wait_next = 1'b1;
                                clr3d_next   = interp_3d_in;
                                state_next   = sdcp_pkg::SDCP_HOME;
                            end
                        end
                        sdcp_pkg::SDCP_CMD_SPEED: begin
                            if (!init_reg) begin
                                reply_next = `SDCP_CH_ERR_NOINIT;
                            end else if (value_reg < `SDCP_SPEED_MIN ||
                                         value_reg > `SDCP_SPEED_MAX) begin
                                reply_next = `SDCP_CH_ERR_SYNTAX;
                            end else begin
                                state_next  = sdcp_pkg::SDCP_SKIP;
                                digits_next = 3'h0;
                            end
                        end
                        default: reply_next = `SDCP_CH_ERR_CMD;
                    endcase
                end
            end
            sdcp_pkg::SDCP_SKIP: begin
                // one field per cycle; the digit counter is free as walk index here
                spd.wr_en   = 1'b1;
                spd.wr_addr = digits_reg[1:0];
                spd.wr_data = (digits_reg == field_reg) ? value_reg : stage_reg[digits_reg[1:0]];
                digits_next = digits_reg + 3'h1;
                if (digits_reg == field_reg) state_next = sdcp_pkg::SDCP_REPLY;
            end
            sdcp_pkg::SDCP_HOME: begin
                if (!rd_wait_reg && axis_done) begin
                    pending_next = pending_reg & ~(4'h1 << axis_reg);
                    axis_next    = next_axis(pending_next);
                    rd_wait_next = 1'b1;
                    if (pending_next == 4'h0) begin
                        state_next = sdcp_pkg::SDCP_REPLY;
                    end
                end
            end
            sdcp_pkg::SDCP_REPLY: begin
                if (tx_ready_in) begin
                    state_next = sdcp_pkg::SDCP_IDLE;
                end
            end
            default: state_next = sdcp_pkg::SDCP_IDLE;
        endcase
    end

    // =====================================================
    // registers
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            state_reg       <= sdcp_pkg::SDCP_IDLE;
            cmd_reg         <= sdcp_pkg::SDCP_CMD_INIT;
            unit_number_reg <= `SDCP_UNIT_DEFAULT;
            value_reg       <= 16'h0000;
            digits_reg      <= 3'h0;
            field_reg       <= 3'h0;
            bad_reg         <= 1'b0;
            config_reg      <= 4'h0;
            init_reg        <= 1'b0;
            pending_reg     <= 4'h0;
            axis_reg        <= `SDCP_AXIS_X;
            reply_reg       <= `SDCP_CH_ACK;
            clr3d_reg       <= 1'b0;
            rd_wait_reg     <= 1'b0;
            stage_reg       <= '{default: 16'h0000};
        end else if (clk_en_in) begin
            state_reg       <= state_next;
            cmd_reg         <= cmd_next;
            unit_number_reg <= unit_number_next;
            value_reg       <= value_next;
            digits_reg      <= digits_next;
            field_reg       <= field_next;
            bad_reg         <= bad_next;
            config_reg      <= config_next;
            init_reg        <= init_next;
            pending_reg     <= pending_next;
            axis_reg        <= axis_next;
            reply_reg       <= reply_next;
            clr3d_reg       <= clr3d_next;
            rd_wait_reg     <= rd_wait_next;
            stage_reg       <= stage_next;
        end
    end

    assign tx_valid_out        = (state_reg == sdcp_pkg::SDCP_REPLY);
    assign tx_data_out         = reply_reg;
    assign interp_3d_clear_out = clr3d_reg;
    assign home_active_out     = (state_reg == sdcp_pkg::SDCP_HOME) && !rd_wait_reg;
    assign home_axis_out       = axis_reg;
    assign home_speed_out      = spd.rd_data;
    assign axis_config_out     = config_reg;
    assign initialised_out     = init_reg;
endmodule

// >>> rtl/sdcp_pkg.sv
// types of the direct-execution command parser
package sdcp_pkg;
    typedef enum logic [2:0] {
        SDCP_IDLE  = 3'b000,
        SDCP_UNIT  = 3'b001,
        SDCP_BODY  = 3'b010,
        SDCP_EXEC  = 3'b011,
        SDCP_HOME  = 3'b100,
        SDCP_REPLY = 3'b101,
        SDCP_SKIP  = 3'b110
    } sdcp_state_type;
    typedef enum logic [1:0] {
        SDCP_CMD_INIT  = 2'b00,
        SDCP_CMD_HOME  = 2'b01,
        SDCP_CMD_SPEED = 2'b10,
        SDCP_CMD_BAD   = 2'b11
    } sdcp_cmd_type;
endpackage

// >>> rtl/sdcp_regs.svh
// constants of the direct-execution command parser
`ifndef SDCP_REGS_SVH
`define SDCP_REGS_SVH
`define SDCP_CH_OPEN        8'h40
`define SDCP_CH_CR          8'h0D
`define SDCP_CH_COMMA       8'h2C
`define SDCP_CH_ZERO        8'h30
`define SDCP_CH_NINE        8'h39
`define SDCP_CH_HOME_UC     8'h52
`define SDCP_CH_HOME_LC     8'h72
`define SDCP_CH_SPEED       8'h64
`define SDCP_CH_ACK         8'h30
`define SDCP_CH_ERR_SYNTAX  8'h31
`define SDCP_CH_ERR_AXES    8'h33
`define SDCP_CH_ERR_CMD     8'h35
`define SDCP_CH_ERR_NOINIT  8'h36
`define SDCP_UNIT_DEFAULT   4'h0
`define SDCP_SPEED_DEFAULT  16'h09C4
`define SDCP_SPEED_MIN      16'h0014
`define SDCP_SPEED_MAX      16'h4E20
`define SDCP_AXES_X         4'h1
`define SDCP_AXES_XY        4'h3
`define SDCP_AXES_XYZ       4'h7
`define SDCP_AXES_A         4'h8
`define SDCP_BIT_X          0
`define SDCP_BIT_Y          1
`define SDCP_BIT_Z          2
`define SDCP_BIT_A          3
`define SDCP_AXIS_X         2'h0
`define SDCP_AXIS_Y         2'h1
`define SDCP_AXIS_Z         2'h2
`define SDCP_AXIS_A         2'h3
`define SDCP_NUM_AXES       3'h4
`define SDCP_DIGIT_MAX      3'h5
`define SDCP_BAUD_RATE      19200
`define SDCP_CLK_HZ         200000000
`define SDCP_BIT_CYCLES     ((`SDCP_CLK_HZ) / (`SDCP_BAUD_RATE))
`endif

// >>> rtl/sdcp_speed_if.sv
// write and read port of the homing speed store
`timescale 1ns/100ps
interface sdcp_speed_if;
    logic        wr_en;
    logic [1:0]  wr_addr;
    logic [15:0] wr_data;
    logic [1:0]  rd_addr;
    logic [15:0] rd_data;
    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr,
                  input rd_data);
    modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr,
                  output rd_data);
endinterface

// >>> rtl/sdcp_speed_mem.sv
// homing speed store, one word per axis, registered read
`timescale 1ns/100ps
`include "sdcp_regs.svh"
module sdcp_speed_mem (
    input  wire logic   clk_sys_in,
    input  wire logic   srst_in,
    input  wire logic   clk_en_in,
    sdcp_speed_if.mem   port
);
    logic [15:0] word_reg [4];
    logic [15:0] word_next [4];
    logic [15:0] rd_reg;
    logic [15:0] rd_next;

    // volatile only: reset restores every axis to the default speed
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            word_next[i] = word_reg[i];
        end
        if (port.wr_en) begin
            word_next[port.wr_addr] = port.wr_data;
        end
        rd_next = word_reg[port.rd_addr];
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            for (int i = 0; i < 4; i++) begin
                word_reg[i] <= `SDCP_SPEED_DEFAULT;
            end
            rd_reg <= `SDCP_SPEED_DEFAULT;
        end else if (clk_en_in) begin
            word_reg <= word_next;
            rd_reg   <= rd_next;
        end
    end

    assign port.rd_data = rd_reg;
endmodule

// >>> testbench/sdcp_host_model.sv
// host computer model: sends framed commands, takes each reply
`timescale 1ns/100ps
`include "sdcp_regs.svh"
module sdcp_host_model (
    input  wire logic       clk_sys_in,
    input  wire logic       tx_valid_out,
    input  wire logic [7:0] tx_data_out,
    output logic [7:0]      rx_data_in,
    output logic            rx_valid_in,
    output logic            tx_ready_in
);
    initial begin
        rx_data_in = 8'hFF;
        rx_valid_in = 1'b0;
        tx_ready_in = 1'b0;
    end
    // gap slows both the bytes and the reply acceptance
    task automatic send_cmd(input string s, input int gap, output logic [7:0] r);
        logic [7:0] b;
        int         n;
        for (int i = 0; i <= s.len(); i++) begin
            b = (i < s.len()) ? s[i] : `SDCP_CH_CR;
            @(posedge clk_sys_in);
            #1;
            rx_data_in = b;
            rx_valid_in = 1'b1;
            @(posedge clk_sys_in);
            #1;
            rx_valid_in = 1'b0;
            // idle line never repeats the last byte
            rx_data_in = ~b;
            repeat (gap) @(posedge clk_sys_in);
        end
        #1;
        n = 0;
        while (tx_valid_out !== 1'b1 && n < 20000) begin
            @(posedge clk_sys_in);
            #1;
            n++;
        end
        r = (n < 20000) ? tx_data_out : 8'hXX;
        repeat (gap) @(posedge clk_sys_in);
        #1;
        tx_ready_in = 1'b1;
        @(posedge clk_sys_in);
        #1;
        tx_ready_in = 1'b0;
    endtask
endmodule

// >>> testbench/sdcp_parser_properties.sv
// port checker of the direct-execution command parser
`timescale 1ns/100ps
`include "sdcp_regs.svh"
module sdcp_props (
    input wire logic       clk_sys_in,
    input wire logic       srst_in,
    input wire logic       tx_valid_out,
    input wire logic [7:0] tx_data_out,
    input wire logic       tx_ready_in,
    input wire logic       interp_3d_clear_out,
    input wire logic [3:0] ref_switch_in,
    input wire logic       stop_button_in,
    input wire logic       home_active_out,
    input wire logic [1:0] home_axis_out,
    input wire logic [3:0] axis_config_out,
    input wire logic       initialised_out
);
    // ==========================================
    // homing rank: Z first, then Y, X, A
    logic [1:0] rank_reg;
    logic [1:0] rank_next;
    logic [1:0] rank_now;
    always_comb begin
        case (home_axis_out)
            2'h0: rank_now = 2'h2;
            2'h2: rank_now = 2'h0;
            default: rank_now = home_axis_out;
        endcase
        rank_next = rank_reg;
        if (tx_valid_out) rank_next = 2'h0;
        else if (home_active_out) rank_next = rank_now;
    end
    always_ff @(posedge clk_sys_in) rank_reg <= srst_in ? 2'h0 : rank_next;
    // ==========================================
    // properties
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);
    property p_reply_stands;
        tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out);
    endproperty
    a_reply_stands: assert property (p_reply_stands) else $error("reply dropped early");
    property p_quiet_homing;
        home_active_out |-> !tx_valid_out;
    endproperty
    a_quiet_homing: assert property (p_quiet_homing) else $error("reply while homing");
    property p_keep_stepping;
        home_active_out && !ref_switch_in[home_axis_out] && !stop_button_in
            |=> home_active_out && $stable(home_axis_out);
    endproperty
    a_keep_stepping: assert property (p_keep_stepping) else $error("axis left early");
    property p_order;
        home_active_out |-> rank_now >= rank_reg;
    endproperty
    a_order: assert property (p_order) else $error("homing order broken");
    property p_needs_init;
        home_active_out |-> initialised_out && axis_config_out[home_axis_out];
    endproperty
    a_needs_init: assert property (p_needs_init) else $error("homing unconfigured axis");
    property p_config_legal;
        initialised_out |-> axis_config_out inside {4'h1, 4'h3, 4'h7, 4'h8};
    endproperty
    a_config_legal: assert property (p_config_legal) else $error("illegal axis config");
    property p_clear_then_home;
        interp_3d_clear_out |-> ##[0:3] home_active_out;
    endproperty
    a_clear_then_home: assert property (p_clear_then_home) else $error("3d clear w/o homing");
    property p_config_acked;
        $changed(axis_config_out) |-> ##[0:3] tx_valid_out && tx_data_out == `SDCP_CH_ACK;
    endproperty
    a_config_acked: assert property (p_config_acked) else $error("config changed w/o ack");
    c_home: cover property ($rose(home_active_out));
    c_err_axes: cover property (tx_valid_out && tx_data_out == `SDCP_CH_ERR_AXES);
    c_clear: cover property (interp_3d_clear_out);
endmodule
bind sdcp_parser sdcp_props u_props (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
    .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out), .tx_ready_in(tx_ready_in),
    .interp_3d_clear_out(interp_3d_clear_out), .ref_switch_in(ref_switch_in),
    .stop_button_in(stop_button_in), .home_active_out(home_active_out),
    .home_axis_out(home_axis_out), .axis_config_out(axis_config_out),
    .initialised_out(initialised_out));

// >>> testbench/test_stepper_direct_command_parser.sv
// testbench of the direct-execution command parser
`timescale 1ns/100ps
`include "sdcp_regs.svh"
module test_stepper_direct_command_parser;
    logic        clk_sys_in, srst_in, rx_valid_in, tx_valid_out, tx_ready_in;
    logic        interp_3d_in, interp_3d_clear_out, stop_button_in, home_active_out;
    logic        initialised_out, use_stop, clr_seen;
    logic [7:0]  rx_data_in, tx_data_out, r;
    logic [3:0]  ref_switch_in, axis_config_out;
    logic [1:0]  home_axis_out;
    logic [15:0] home_speed_out, spd;
    logic [1:0]  order[$];
    int          errors, n_checks, cnt;
    sdcp_parser DUT (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .clk_en_in(1'b1),
        .rx_data_in(rx_data_in), .rx_valid_in(rx_valid_in), .tx_valid_out(tx_valid_out),
        .tx_data_out(tx_data_out), .tx_ready_in(tx_ready_in), .interp_3d_in(interp_3d_in),
        .interp_3d_clear_out(interp_3d_clear_out), .ref_switch_in(ref_switch_in),
        .stop_button_in(stop_button_in), .home_active_out(home_active_out),
        .home_axis_out(home_axis_out), .home_speed_out(home_speed_out),
        .axis_config_out(axis_config_out), .initialised_out(initialised_out));
    sdcp_host_model host (.clk_sys_in(clk_sys_in), .tx_valid_out(tx_valid_out),
        .tx_data_out(tx_data_out), .rx_data_in(rx_data_in), .rx_valid_in(rx_valid_in),
        .tx_ready_in(tx_ready_in));
    initial begin
        clk_sys_in = 1'b0;
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end
    // ==========================================
    // mechanics: each axis hits its switch after six steps, or the stop button is pressed instead when use_stop is set
    always @(posedge clk_sys_in) begin
        #1;
        if (interp_3d_clear_out === 1'b1) clr_seen = 1'b1;
        if (tx_valid_out === 1'b1 || srst_in) begin
            ref_switch_in = 4'h0;
            stop_button_in = 1'b0;
            cnt = 0;
        end else if (home_active_out === 1'b1) begin
            if (order.size() == 0 || order[$] !== home_axis_out) order.push_back(home_axis_out);
            spd = home_speed_out;
            cnt++;
            if (cnt == 6) begin
                if (use_stop) stop_button_in = 1'b1;
                else ref_switch_in[home_axis_out] = 1'b1;
                cnt = 0;
            end
        end
    end
    // ==========================================
    // compare, closing and reset tasks
    task automatic check_reply(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic do_reset();
        @(posedge clk_sys_in);
        #1;
        srst_in = 1'b1;
        repeat (20) @(posedge clk_sys_in);
        #1;
        srst_in = 1'b0;
    endtask
    // ==========================================
    // scenarios
    task automatic t_reset_state();
        check_val("config", 16'h0, axis_config_out);
        check_val("initialised", 16'h0, initialised_out);
        check_val("tx valid", 16'h0, tx_valid_out);
    endtask
    task automatic do_home(input string s, input logic [1:0] exp[$], input logic [15:0] sp);
        order.delete();
        host.send_cmd(s, 2, r);
        check_reply(s, `SDCP_CH_ACK, r);
        check_val("axes homed", 16'(exp.size()), 16'(order.size()));
        foreach (exp[i]) check_val("homed axis", exp[i], order[i]);
        check_val("homing speed", sp, spd);
    endtask
    task automatic t_init();
        int bad[5] = '{0, 2, 4, 6, 9};
        int good[4] = '{8, 1, 3, 7};
        host.send_cmd("@0R1", 0, r);
        check_reply("home before init", `SDCP_CH_ERR_NOINIT, r);
        foreach (bad[i]) begin
            host.send_cmd($sformatf("@0%0d", bad[i]), 0, r);
            check_reply("init refused", `SDCP_CH_ERR_AXES, r);
            check_val("initialised", 16'h0, initialised_out);
        end
        // fourth axis alone, then the others
        foreach (good[i]) begin
            host.send_cmd($sformatf("@0%0d", good[i]), 1, r);
            check_reply("init", `SDCP_CH_ACK, r);
            check_val("config", 16'(good[i]), axis_config_out);
            check_val("initialised", 16'h1, initialised_out);
        end
    endtask
    task automatic t_bad_frames();
        host.send_cmd("@0Q5", 0, r);
        check_reply("unknown letter", `SDCP_CH_ERR_CMD, r);
        host.send_cmd("@17", 0, r);
        check_reply("wrong unit refused", `SDCP_CH_ERR_SYNTAX, r);
        host.send_cmd("@0d5", 0, r);
        check_reply("slow speed refused", `SDCP_CH_ERR_SYNTAX, r);
        host.send_cmd("@0d70000", 0, r);
        check_reply("overlong speed refused", `SDCP_CH_ERR_SYNTAX, r);
        check_val("config kept", 16'h7, axis_config_out);
    endtask
    task automatic t_homing();
        interp_3d_in = 1'b1;
        clr_seen = 1'b0;
        do_home("@0R7", '{2'h2, 2'h1, 2'h0}, `SDCP_SPEED_DEFAULT);
        check_val("3d cleared", 16'h1, clr_seen);
        interp_3d_in = 1'b0;
        do_home("@0r5", '{2'h2, 2'h0}, `SDCP_SPEED_DEFAULT);
        host.send_cmd("@0R8", 0, r);
        check_reply("unconfigured axis", `SDCP_CH_ERR_AXES, r);
        use_stop = 1'b1;
        do_home("@0R2", '{2'h1}, `SDCP_SPEED_DEFAULT);
        use_stop = 1'b0;
    endtask
    task automatic t_speeds();
        host.send_cmd("@0d2400,3000", 1, r);
        check_reply("speed set", `SDCP_CH_ACK, r);
        do_home("@0R2", '{2'h1}, 16'h0BB8);
        do_home("@0R1", '{2'h0}, 16'h0960);
        do_reset();
        t_reset_state();
        host.send_cmd("@03", 0, r);
        check_reply("reinit", `SDCP_CH_ACK, r);
        do_home("@0R2", '{2'h1}, `SDCP_SPEED_DEFAULT);
    endtask
    initial begin
        srst_in = 1'b1;
        interp_3d_in = 1'b0;
        stop_button_in = 1'b0;
        ref_switch_in = 4'h0;
        use_stop = 1'b0;
        clr_seen = 1'b0;
        errors = 0;
        n_checks = 0;
        cnt = 0;
        do_reset();
        t_reset_state();
        t_init();
        t_bad_frames();
        t_homing();
        t_speeds();
        give_verdict();
    end
    // run needs well under 20000 cycles
    initial begin
        #400000;
        errors++;
        give_verdict();
    end
endmodule
